// [rtl/qdt_pkg.sv]
package qdt_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_COUNT = 4'h0;
  localparam logic [3:0] OFS_MODE = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;
  // mode register fields
  localparam int MB_ONESHOT = 0;
  localparam int MB_TWO_PHASE = 1;
  localparam int MB_CLK_SEL1 = 2;
  localparam int MB_FREE_RUN = 3;
  localparam int MB_PULSE_EN = 4;
  localparam int MB_SRC_LO = 5;
  localparam int MB_TRIG_LO = 8;
  localparam int MB_POL = 10;
  localparam int MB_ZINIT = 11;
  localparam int MODE_W = 12;
  // control register fields
  localparam int CB_RUN = 0;
  localparam int CB_SOFT_TRIG = 1;
  // reset values, undefined count read and count maximum
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
  localparam logic [15:0] UNDEF_READ = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // count source choices
  typedef enum logic [2:0] {
    SRC_F1 = 3'b000,
    SRC_F2 = 3'b001,
    SRC_F8 = 3'b010,
    SRC_F32 = 3'b011,
    SRC_FC32 = 3'b100
  } qdt_src_t;
  localparam logic [4:0] DIV_MASK_F2 = 5'h01;
  localparam logic [4:0] DIV_MASK_F8 = 5'h07;
  localparam logic [4:0] DIV_MASK_F32 = 5'h1F;
  // trigger choices, {trigger_select_hi, trigger_select_lo}
  typedef enum logic [1:0] {
    TRG_PIN = 2'b00,
    TRG_B2 = 2'b01,
    TRG_LOWER = 2'b10,
    TRG_UPPER = 2'b11
  } qdt_trig_t;
  localparam int CH_QUAD_SEL = 3;
  localparam int CH_QUAD_X4 = 4;
  localparam int CH_FIRST = 0;
  localparam int CH_LAST = 4;
endpackage : qdt_pkg

// [rtl/qdt_pre_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface qdt_pre_if;
  logic [2:0] sel;
  logic tick;
  modport ctl (output sel, input tick);
  modport div (input sel, output tick);
endinterface : qdt_pre_if
`default_nettype wire

// [rtl/qdt_prescale.sv]
`timescale 1ns/1ps
`default_nettype none
module qdt_prescale (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // subclock enable pulse
  input wire logic sub_tick_in,
  // count source link
  qdt_pre_if.div pre
);
  typedef struct packed {
    logic [4:0] div;
    logic [4:0] sub;
    logic tick;
  } qdt_pre_st_t;
  qdt_pre_st_t s_r, s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.div = s_r.div + 5'h01;
    if (sub_tick_in)
    begin
      s_nxt.sub = s_r.sub + 5'h01;
    end
    case (pre.sel)
      qdt_pkg::SRC_F1: s_nxt.tick = 1'b1;
      qdt_pkg::SRC_F2:
        s_nxt.tick = (s_r.div & qdt_pkg::DIV_MASK_F2) == qdt_pkg::DIV_MASK_F2;
      qdt_pkg::SRC_F8:
        s_nxt.tick = (s_r.div & qdt_pkg::DIV_MASK_F8) == qdt_pkg::DIV_MASK_F8;
      qdt_pkg::SRC_F32: s_nxt.tick = s_r.div == qdt_pkg::DIV_MASK_F32;
      qdt_pkg::SRC_FC32:
        s_nxt.tick = sub_tick_in && s_r.sub == qdt_pkg::DIV_MASK_F32;
      default: s_nxt.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pre.tick = s_r.tick;
endmodule : qdt_prescale
`default_nettype wire

// [rtl/qdt_timer.sv]
// Behaviour
// - channel 3 picks normal or x4 by clock_select_1; 2 normal, 4 x4.
// - a recognised Z-phase index forces the counter to zero.
// - zeroing only on channel 3, event, two-phase, free-run, x4.
// - Z-phase edge is rising or falling per edge_polarity_bit.
// - zeroing happens at the next count-source tick after recognition.
// - wrap coinciding with zeroing gives two successive requests.
// - x4 counts all edges up or down by phase of the two pins.
// - one-shot count source is f1, f2, f8, f32 or subclock/32.
// - one-shot counts down, reloads on reaching zero, then stops.
// - a trigger while running reloads and restarts the count.
// - period is n ticks from the count; n of zero never runs.
// - start needs channel_run_flag set plus one of the triggers.
// - neighbour triggers from i-1 and i+1, no wrap at 0 and 4.
// - one-shot stops after the final reload or when run is cleared.
// - one-shot request is raised when the counter reaches zero.
// - count reads in one-shot mode give no live count.
// - writes before first tick load counter too; later only reload.
// - pulse output low while idle, high while counting, if selected.
`timescale 1ns/1ps
`default_nettype none
module qdt_timer #(
  parameter int CHANNEL_ID = 3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // pins and trigger sources
  input wire logic timer_in_pin_in,
  input wire logic timer_out_pin_in,
  input wire logic ext_pin_a_in,
  input wire logic sub_tick_in,
  input wire logic b2_wrap_in,
  input wire logic lower_wrap_in,
  input wire logic upper_wrap_in,
  // outputs
  output logic pulse_out,
  output logic pulse_oe_out,
  output logic irq_out,
  output logic wrap_out
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] reload;
    logic [qdt_pkg::MODE_W-1:0] mode;
    logic run;
    logic running;
    logic ticked;
    logic zpend;
    logic irq;
    logic irq2;
    logic wrap;
    logic a_q;
    logic b_q;
    logic z_q;
    logic waitreq;
    logic [31:0] rdata;
    logic pulse;
    logic pulse_oe;
  } qdt_state_t;
  qdt_state_t s_r, s_nxt;

  qdt_pre_if pre ();
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic quad_x4(input logic cs1);
    if (CHANNEL_ID == qdt_pkg::CH_QUAD_X4)
    begin
      return 1'b1;
    end
    else if (CHANNEL_ID == qdt_pkg::CH_QUAD_SEL)
    begin
      return cs1;
    end
    else
    begin
      return 1'b0;
    end
  endfunction : quad_x4

  qdt_prescale u_pre (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .sub_tick_in(sub_tick_in),
    .pre(pre.div)
  );
  assign pre.sel = s_r.mode[qdt_pkg::MB_SRC_LO +: 3];
  assign tick = pre.tick;

  ////////////////////////////////////////////////////////////////////////////
  logic oneshot, two_ph, x4, zero_en, zedge, up, dn, edge_any, trig;
  logic wrap_now, zero_now, wr_take;
  logic [1:0] tsel;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.irq = 1'b0;
    s_nxt.irq2 = 1'b0;
    s_nxt.wrap = 1'b0;
    s_nxt.a_q = timer_in_pin_in;
    s_nxt.b_q = timer_out_pin_in;
    s_nxt.z_q = ext_pin_a_in;
    oneshot = s_r.mode[qdt_pkg::MB_ONESHOT];
    two_ph = s_r.mode[qdt_pkg::MB_TWO_PHASE] && !oneshot;
    x4 = quad_x4(s_r.mode[qdt_pkg::MB_CLK_SEL1]);
    tsel = s_r.mode[qdt_pkg::MB_TRIG_LO +: 2];
    zero_en = CHANNEL_ID == qdt_pkg::CH_QUAD_SEL && two_ph && x4
      && s_r.mode[qdt_pkg::MB_FREE_RUN] && s_r.mode[qdt_pkg::MB_ZINIT];
    zedge = s_r.mode[qdt_pkg::MB_POL] ? (ext_pin_a_in && !s_r.z_q)
      : (!ext_pin_a_in && s_r.z_q);
    edge_any = (timer_in_pin_in != s_r.a_q) || (timer_out_pin_in != s_r.b_q);
    if (x4)
    begin
      up = edge_any && (s_r.a_q ^ timer_out_pin_in);
      dn = edge_any && !(s_r.a_q ^ timer_out_pin_in);
    end
    else
    begin
      up = timer_in_pin_in && !s_r.a_q && timer_out_pin_in;
      dn = !timer_in_pin_in && s_r.a_q && timer_out_pin_in;
    end
    wrap_now = 1'b0;
    zero_now = 1'b0;
    case (tsel)
      qdt_pkg::TRG_PIN: trig = timer_in_pin_in && !s_r.a_q;
      qdt_pkg::TRG_B2: trig = b2_wrap_in;
      qdt_pkg::TRG_LOWER:
        trig = lower_wrap_in && CHANNEL_ID != qdt_pkg::CH_FIRST;
      qdt_pkg::TRG_UPPER:
        trig = upper_wrap_in && CHANNEL_ID != qdt_pkg::CH_LAST;
      default: trig = 1'b0;
    endcase
    wr_take = avs_write_in && !s_r.waitreq;
    if (wr_take && avs_address_in == qdt_pkg::OFS_CTRL
        && avs_writedata_in[qdt_pkg::CB_SOFT_TRIG])
    begin
      trig = 1'b1;
    end

    if (tick && s_r.run)
    begin
      s_nxt.ticked = 1'b1;
    end
    if (!s_r.run)
    begin
      s_nxt.running = 1'b0;
      s_nxt.ticked = 1'b0;
    end
    else if (!oneshot)
    begin
      if (two_ph && (up || dn))
      begin
        wrap_now = up ? (s_r.cnt == qdt_pkg::CNT_MAX)
          : (s_r.cnt == qdt_pkg::CNT_RST);
        if (wrap_now && !s_r.mode[qdt_pkg::MB_FREE_RUN])
        begin
          s_nxt.cnt = s_r.reload;
        end
        else
        begin
          s_nxt.cnt = up ? s_r.cnt + 16'h0001 : s_r.cnt - 16'h0001;
        end
      end
      // set wins over the clear of the pending index
      if (s_r.zpend && tick && zero_en)
      begin
        s_nxt.cnt = qdt_pkg::CNT_RST;
        s_nxt.zpend = 1'b0;
        zero_now = 1'b1;
      end
      if (zero_en && zedge)
      begin
        s_nxt.zpend = 1'b1;
      end
    end
    else if (trig && s_r.reload != qdt_pkg::CNT_RST)
    begin
      s_nxt.cnt = s_r.reload;
      s_nxt.running = 1'b1;
      s_nxt.ticked = 1'b0;
    end
    else if (s_r.running && tick)
    begin
      if (s_r.cnt <= 16'h0001)
      begin
        s_nxt.cnt = s_r.reload;
        s_nxt.running = 1'b0;
        s_nxt.irq = 1'b1;
        s_nxt.wrap = 1'b1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
    end
    if (!zero_en)
    begin
      s_nxt.zpend = 1'b0;
    end
    if (wrap_now)
    begin
      s_nxt.irq = 1'b1;
      s_nxt.wrap = 1'b1;
      s_nxt.irq2 = zero_now;
    end
    if (s_r.irq2)
    begin
      s_nxt.irq = 1'b1;
    end

    // bus: one wait cycle, then taken with waitrequest low
    s_nxt.waitreq = !((avs_read_in || avs_write_in) && s_r.waitreq);
    if (avs_read_in && s_r.waitreq)
    begin
      case (avs_address_in)
        qdt_pkg::OFS_COUNT:
          s_nxt.rdata = {16'h0000,
            oneshot ? qdt_pkg::UNDEF_READ : s_r.cnt};
        qdt_pkg::OFS_MODE: s_nxt.rdata = {20'h00000, s_r.mode};
        qdt_pkg::OFS_CTRL: s_nxt.rdata = {31'h00000000, s_r.run};
        qdt_pkg::OFS_STAT:
          s_nxt.rdata = {16'h0000, s_r.cnt[15:14], 12'h000,
            s_r.zpend, s_r.running};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
    if (wr_take)
    begin
      case (avs_address_in)
        qdt_pkg::OFS_COUNT:
        begin
          s_nxt.reload = avs_writedata_in[15:0];
          if (!s_r.run || !s_r.ticked)
          begin
            s_nxt.cnt = avs_writedata_in[15:0];
          end
        end
        qdt_pkg::OFS_MODE: s_nxt.mode = avs_writedata_in[qdt_pkg::MODE_W-1:0];
        qdt_pkg::OFS_CTRL:
        begin
          s_nxt.run = avs_writedata_in[qdt_pkg::CB_RUN];
          if (!s_r.run)
          begin
            s_nxt.ticked = 1'b0;
          end
        end
        default: s_nxt.run = s_r.run;
      endcase
    end

    s_nxt.pulse_oe = oneshot && s_r.mode[qdt_pkg::MB_PULSE_EN];
    s_nxt.pulse = s_nxt.pulse_oe && s_nxt.running;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      s_r <= '0;
      s_r.waitreq <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_out = s_r.rdata;
  assign avs_waitrequest_out = s_r.waitreq;
  assign pulse_out = s_r.pulse;
  assign pulse_oe_out = s_r.pulse_oe;
  assign irq_out = s_r.irq;
  assign wrap_out = s_r.wrap;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence zero_req_s;
    s_r.zpend && tick && zero_en && s_r.run && !oneshot;
  endsequence
  sequence two_irq_s;
    s_r.irq ##1 s_r.irq;
  endsequence
  sequence zero_wrap_s;
    zero_req_s ##0 wrap_now;
  endsequence

  zero_on_tick_a: assert property (zero_req_s |=> s_r.cnt == 16'h0000)
    else $error("index zeroing missed");
  zero_gate_a: assert property ($rose(s_r.zpend) |-> $past(zero_en))
    else $error("index armed while disabled");
  zero_edge_a: assert property (zero_en && zedge && s_r.run
    |=> s_r.zpend)
    else $error("index edge not recognised");
  double_irq_a: assert property (zero_wrap_s |=> two_irq_s)
    else $error("second request missing");
  start_run_a: assert property (oneshot && s_r.run && trig
    && s_r.reload != 16'h0000 |=> s_r.running && s_r.cnt == $past(s_r.reload))
    else $error("one-shot did not start");
  zero_period_a: assert property (oneshot && !s_r.running
    && s_r.reload == 16'h0000 && !wr_take |=> !s_r.running)
    else $error("zero period started");
  run_clear_a: assert property (!s_r.run |=> !s_r.running)
    else $error("counting without run flag");
  end_shot_a: assert property (oneshot && s_r.run && s_r.running
    && tick && !trig && s_r.cnt == 16'h0001 |=> !s_r.running && irq_out)
    else $error("one-shot end wrong");
  pulse_track_a: assert property (s_r.pulse_oe
    |-> pulse_out == s_r.running)
    else $error("pulse level wrong");
  up_step_a: assert property (!oneshot && s_r.run && two_ph && x4
    && up && !wrap_now && !zero_now && !wr_take
    |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("x4 up count wrong");
  read_undef_a: assert property (oneshot && avs_read_in && s_r.waitreq
    && avs_address_in == qdt_pkg::OFS_COUNT
    |=> avs_readdata_out == {16'h0000, qdt_pkg::UNDEF_READ})
    else $error("live count read in one-shot");
  load_both_a: assert property (wr_take && !s_r.run
    && avs_address_in == qdt_pkg::OFS_COUNT |=> s_r.cnt == s_r.reload)
    else $error("stopped write missed counter");
  wrap_irq_a: assert property (wrap_now |=> irq_out && wrap_out)
    else $error("wrap without request");
endmodule : qdt_timer
`default_nettype wire

// [tb/qdt_enc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module qdt_enc_model (
  // clock
  input wire logic clk_in,
  // encoder and trigger lines
  output logic a_out,
  output logic b_out,
  output logic z_out
);
  logic [1:0] ph;
  initial
  begin
    ph = 2'h0;
    a_out = 1'b0;
    b_out = 1'b0;
    z_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // gray walk; b leads a when going up, spaced so every edge is seen
  task automatic step(input bit up);
    @(posedge clk_in);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    a_out <= ph[1];
    b_out <= ph[1] ^ ph[0];
    repeat (3) @(posedge clk_in);
  endtask : step
  task automatic trig();
    @(posedge clk_in);
    a_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    a_out <= 1'b0;
  endtask : trig
  task automatic zlevel(input bit v);
    @(posedge clk_in);
    z_out <= v;
  endtask : zlevel
  // held two ticks of the f1 source, longer than one period
  task automatic zpulse(input bit v);
    @(posedge clk_in);
    z_out <= v;
    repeat (2) @(posedge clk_in);
    z_out <= !v;
  endtask : zpulse
endmodule : qdt_enc_model
`default_nettype wire

// [tb/quad_decode_oneshot_timer_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module quad_decode_oneshot_timer_test;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic wreq;
  logic pin_a;
  logic pin_b;
  logic pin_z;
  logic sub_t = 1'b0;
  logic [1:0] sub_k = 2'h0;
  logic [3:0] radr [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  logic b2w = 1'b0;
  logic low_w = 1'b0;
  logic up_w = 1'b0;
  logic pulse;
  logic oe;
  logic irq;
  logic wrap;
  int fails = 0;
  int cmp_count = 0;
  int len;
  int irqs;
  int wraps;
  int exp_cnt;
  int ph = 0;
  int n;
  always #4 clk_in = ~clk_in;
  // subclock enable once every fourth cycle
  always @(posedge clk_in)
  begin
    sub_k <= sub_k + 2'h1;
    sub_t <= (sub_k == 2'h3);
  end
  qdt_enc_model enc (.clk_in(clk_in), .a_out(pin_a), .b_out(pin_b),
    .z_out(pin_z));
  qdt_timer #(.CHANNEL_ID(3)) uut (.clk_in(clk_in), .reset_in(reset_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .timer_in_pin_in(pin_a),
    .timer_out_pin_in(pin_b), .ext_pin_a_in(pin_z), .sub_tick_in(sub_t),
    .b2_wrap_in(b2w), .lower_wrap_in(low_w), .upper_wrap_in(up_w),
    .pulse_out(pulse), .pulse_oe_out(oe), .irq_out(irq), .wrap_out(wrap));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // one avalon access; the edge that sees waitrequest low completes it
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk_in);
      k++;
    end
    while (wreq !== 1'b0 && k < 20);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      print_verdict();
    end
  endtask : bus
  task automatic measure(input int m);
    len = 0;
    irqs = 0;
    wraps = 0;
    repeat (m)
    begin
      @(posedge clk_in);
      if (pulse === 1'b1) len++;
      if (irq === 1'b1) irqs++;
      if (wrap === 1'b1) wraps++;
    end
  endtask : measure
  task automatic fire(input int t);
    if (t == 0) enc.trig();
    else
    begin
      @(posedge clk_in);
      b2w <= (t == 1);
      low_w <= (t == 2);
      up_w <= (t == 3);
      @(posedge clk_in);
      {b2w, low_w, up_w} <= 3'h0;
    end
  endtask : fire
  // reference decoder: dm 0 down, 1 up, 2 random
  task automatic steps(input int k, input bit x4, input int dm);
    bit up;
    for (int i = 0; i < k; i++)
    begin
      up = (dm == 2) ? 1'($urandom_range(1)) : dm[0];
      if (x4) exp_cnt += up ? 1 : -1;
      else if (up && ph == 1) exp_cnt++;
      else if (!up && ph == 2) exp_cnt--;
      ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
      enc.step(up);
    end
  endtask : steps
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(41));
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (radr[i])
    begin
      bus(0, radr[i], 32'h0);
      `CHK("reset read", 32'h0, rv)
    end
    $display("test reset done");
    n = 2 + $urandom_range(30);
    bus(1, 4'h4, 32'h011);
    bus(1, 4'h0, n);
    bus(1, 4'h8, 32'h1);
    `CHK("pulse oe", 1'b1, oe)
    `CHK("idle low", 1'b0, pulse)
    fork measure(80); bus(1, 4'h8, 32'h3); join
    `CHK("soft len", n, len)
    `CHK("irq count", 1, irqs)
    `CHK("wrap count", 1, wraps)
    bus(0, 4'hC, 32'h0);
    `CHK("stopped", 1'b0, rv[0])
    bus(1, 4'h0, 32'h0);
    fork measure(30); bus(1, 4'h8, 32'h3); join
    `CHK("zero len", 0, len)
    bus(1, 4'h0, 32'h14);
    fork
      measure(60);
      begin
        bus(1, 4'h8, 32'h3);
        bus(1, 4'h0, 32'h5);
        bus(0, 4'h0, 32'h0);
      end
    join
    `CHK("busy len", 20, len)
    `CHK("count read", {16'h0, qdt_pkg::UNDEF_READ}, rv)
    fork measure(30); bus(1, 4'h8, 32'h3); join
    `CHK("reload len", 5, len)
    $display("test one-shot soft done");
    bus(1, 4'h0, 32'h6);
    for (int t = 0; t < 4; t++)
    begin
      bus(1, 4'h4, 32'h011 | (t << 8));
      fork measure(30); fire(t); join
      `CHK("trig len", 6, len)
    end
    bus(1, 4'h4, 32'h011);
    bus(1, 4'h8, 32'h0);
    fork measure(30); fire(0); join
    `CHK("no run len", 0, len)
    bus(1, 4'h0, 32'h8);
    bus(1, 4'h8, 32'h1);
    fork measure(40); begin fire(0); repeat (2) @(posedge clk_in); fire(0); end
    join
    `CHK("retrig len", 13, len)
    bus(1, 4'h0, 32'h28);
    fork measure(60); begin fire(0); bus(1, 4'h8, 32'h0); end join
    `CHK("cut short", 1'b1, len < 20)
    `CHK("cut irq", 0, irqs)
    `CHK("cut low", 1'b0, pulse)
    $display("test one-shot triggers done");
    // three ticks of each slower source; the first tick may come early
    for (int s = 1; s < 5; s++)
    begin
      n = (s == 4) ? 128 : (1 << (2 * s - 1));
      bus(1, 4'h4, 32'h011 | (s << 5));
      bus(1, 4'h0, 32'h3);
      bus(1, 4'h8, 32'h1);
      fork measure(420); bus(1, 4'h8, 32'h3); join
      `CHK("src len", 1'b1, len > 2 * n && len <= 3 * n)
      bus(1, 4'h8, 32'h0);
    end
    $display("test count source done");
    for (int m = 0; m < 2; m++)
    begin
      bus(1, 4'h0, 32'h0);
      bus(1, 4'h4, 32'h00A | (m << 2));
      bus(1, 4'h8, 32'h1);
      `CHK("oe off", 1'b0, oe)
      exp_cnt = 0;
      steps(3, m, 0);
      steps(16, m, 2);
      bus(0, 4'h0, 32'h0);
      `CHK("quad count", 16'(exp_cnt), rv[15:0])
      bus(1, 4'h8, 32'h0);
    end
    $display("test quadrature done");
    for (int p = 1; p >= 0; p--)
    begin
      bus(1, 4'h0, 32'h0);
      bus(1, 4'h4, 32'h80E | (p << 10));
      enc.zlevel(!p);
      bus(1, 4'h8, 32'h1);
      exp_cnt = 0;
      steps(5, 1, 1);
      bus(0, 4'h0, 32'h0);
      `CHK("pre index", 16'(exp_cnt), rv[15:0])
      enc.zpulse(p);
      repeat (4) @(posedge clk_in);
      bus(0, 4'h0, 32'h0);
      `CHK("index zero", 16'h0000, rv[15:0])
      // down step from zero lands on the zeroing tick
      fork
        measure(20);
        enc.zpulse(p);
        begin
          @(posedge clk_in);
          steps(1, 1, 0);
        end
      join
      `CHK("double irq", 2, irqs)
      `CHK("wrap seen", 1, wraps)
      bus(0, 4'h0, 32'h0);
      `CHK("wrap zeroed", 16'h0000, rv[15:0])
      bus(1, 4'h8, 32'h0);
    end
    $display("test index done");
    print_verdict();
  end
endmodule : quad_decode_oneshot_timer_test
`default_nettype wire
